/* hw/lpmm_pkg.sv */
// package for the low power mode manager: modes, timing, carriers
package lpmm_pkg;
	localparam int CLK_MHZ = 125;
	localparam int SLEEP_WAKE_CYC = 9;
	localparam int STOP0_WAKE_NS = 1700;
	localparam int STOP1_WAKE_NS = 4700;
	localparam int STBY_WAKE_NS = 51000;
	localparam int SHDN_WAKE_NS = 51000;
	localparam int STOP0_WAKE_CYC = (STOP0_WAKE_NS * CLK_MHZ) / 1000;
	localparam int STOP1_WAKE_CYC = (STOP1_WAKE_NS * CLK_MHZ) / 1000;
	localparam int STBY_WAKE_CYC = (STBY_WAKE_NS * CLK_MHZ) / 1000;
	localparam int SHDN_WAKE_CYC = (SHDN_WAKE_NS * CLK_MHZ) / 1000;
	localparam int NUM_IO = 16;
	localparam int NUM_OSC_REQ = 4;
	localparam logic [1:0] PULL_FLOAT = 2'h0;
	localparam logic [1:0] PULL_UP = 2'h1;
	localparam logic [1:0] PULL_DOWN = 2'h2;
	localparam logic [15:0] OPT_EN_RST = 16'h0000;

	typedef enum logic [2:0] {
		MODE_SLEEP = 3'h0,
		MODE_LOW_POWER_SLEEP_MODE = 3'h1,
		MODE_STOP0 = 3'h2,
		MODE_STOP1 = 3'h3,
		MODE_STANDBY = 3'h4,
		MODE_SHUTDOWN = 3'h5
	} lpmm_mode_t;

	typedef enum logic [2:0] {
		ST_RUN = 3'h0,
		ST_LOWPWR = 3'h1,
		ST_WAKE = 3'h2
	} lpmm_state_t;

	// wake sources, one bit each
	typedef struct packed {
		logic resetPin;
		logic anyIo;
		logic radio;
		logic brownout;
		logic voltMon;
		logic rtc;
		logic watchdog;
		logic comparator;
		logic serialA;
		logic serialB;
		logic twoWire;
		logic lpTimer0;
		logic lpTimer1;
		logic wakePinA;
		logic wakePinB;
		logic anyIrq;
	} lpmm_wake_t;

	// serial wake events per port
	typedef struct packed {
		logic startBit;
		logic addrMatch;
		logic frameDone;
	} lpmm_uart_ev_t;

	// power domain controls
	typedef struct packed {
		logic mainReg;
		logic lowPwrReg;
		logic cpuClk;
		logic flashOn;
		logic sramOn;
		logic periphRun;
		logic wakePeriphRun;
		logic alwaysOnRun;
		logic pllAllowed;
		logic radioAvail;
		logic rngAvail;
		logic stepDownOn;
	} lpmm_pwr_t;
endpackage

/* hw/lpmm_manager.sv */
// low power mode manager: mode sequencing, wake, oscillators, pad states
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - optional functions disabled until software enables
// - fast internal oscillator served per stop requester
// - both serial ports wake on start/address/frame
// - two-wire port wakes only on address match
// - standby pads hold chosen pull or float
// - shutdown pad settings dropped on exit
// - two wake pins wake standby and shutdown
// - sleep stops cpu and fast crystal, wakes in 9 cycles
// - low-power modes: low regulator, no pll/radio/rng
// - stop 0 main regulator, flash off, 1.7 us
// - stop modes accept listed wake sources
// - shutdown keeps slow crystal, rtc; pins or rtc
// - stop enables fast crystal for radio activity
// - ram bank clocks gated independently in sleep
// - flash power-down only radio idle, running ram
// - pads analog, trigger off during and after reset
// - reset pin pull-up off on internal reset
module lpmm_manager (
	input  wire logic                                   mclk,
	input  wire logic                                   nrst,
	input  wire logic                                   sleepReq,
	input  wire lpmm_pkg::lpmm_mode_t                   modeSel,
	input  wire logic                                   lowPowerRunSel,
	input  wire logic [15:0]                            optEnable,
	input  wire logic [lpmm_pkg::NUM_OSC_REQ-1:0]       fastOscReq,
	input  wire logic                                   radioActive,
	input  wire lpmm_pkg::lpmm_uart_ev_t                uartEvA,
	input  wire lpmm_pkg::lpmm_uart_ev_t                uartEvB,
	input  wire logic                                   twoWireAddrMatch,
	input  wire lpmm_pkg::lpmm_wake_t                   wakeRaw,
	input  wire logic [1:0]                             ramBankGate,
	input  wire logic                                   flashPdReq,
	input  wire logic                                   execFromRam,
	input  wire logic [2*lpmm_pkg::NUM_IO-1:0]          padPullCfg,
	input  wire logic                                   padCfgDone,
	input  wire logic                                   internalReset,
	output var lpmm_pkg::lpmm_pwr_t                     pwrCtl,
	output var lpmm_pkg::lpmm_state_t                   stateOut,
	output logic [15:0]                                 optActive,
	output logic [lpmm_pkg::NUM_OSC_REQ-1:0]            fastOscGrant,
	output logic                                        fastOscOn,
	output logic                                        fastXtalOn,
	output logic                                        slowXtalOn,
	output logic                                        serialWakeIrq,
	output logic                                        twoWireWakeIrq,
	output logic [1:0]                                  ramBankClkEn,
	output logic                                        flashPowerDown,
	output logic [2*lpmm_pkg::NUM_IO-1:0]               padPull,
	output logic                                        padAnalog,
	output logic                                        padTriggerEn,
	output logic                                        resetPullUpEn,
	output logic                                        wakeDone
);
	import lpmm_pkg::*;

	function automatic logic isStop(input lpmm_mode_t m);
		isStop = (m == MODE_STOP0) || (m == MODE_STOP1);
	endfunction

	function automatic logic isSleep(input lpmm_mode_t m);
		isSleep = (m == MODE_SLEEP) || (m == MODE_LOW_POWER_SLEEP_MODE);
	endfunction

	lpmm_state_t       state_ff;
	lpmm_state_t       nxt_state;
	lpmm_mode_t        mode_ff;
	lpmm_mode_t        nxt_mode;
	logic [15:0]       wakeCnt_ff;
	logic [15:0]       nxt_wakeCnt;
	logic [2*NUM_IO-1:0] padPull_ff;
	logic [2*NUM_IO-1:0] nxt_padPull;
	logic              padCfg_ff;
	logic              nxt_padCfg;
	logic [NUM_OSC_REQ-1:0] grant_ff;
	logic [NUM_OSC_REQ-1:0] nxt_grant;
	logic              serIrq_ff;
	logic              nxt_serIrq;
	logic              twIrq_ff;
	logic              nxt_twIrq;
	logic              wakeHit;
	logic              inStop;
	logic              inLow;
	logic [15:0]       wakeLen;

	assign inLow = (state_ff == ST_LOWPWR);
	assign inStop = inLow && isStop(mode_ff);

	// wake qualification per mode
	always_comb begin
		wakeHit = 1'b0;
		unique case (mode_ff)
			MODE_SLEEP, MODE_LOW_POWER_SLEEP_MODE: begin
				wakeHit = wakeRaw.anyIrq;
			end
			MODE_STOP0, MODE_STOP1: begin
				wakeHit = wakeRaw.resetPin | wakeRaw.anyIo | wakeRaw.radio |
					wakeRaw.brownout | wakeRaw.voltMon | wakeRaw.rtc |
					wakeRaw.watchdog | wakeRaw.comparator | serIrq_ff |
					twIrq_ff | wakeRaw.lpTimer0 | wakeRaw.lpTimer1 |
					wakeRaw.serialA | wakeRaw.serialB | wakeRaw.twoWire;
			end
			MODE_STANDBY: begin
				wakeHit = wakeRaw.resetPin | wakeRaw.wakePinA | wakeRaw.wakePinB |
					wakeRaw.brownout | wakeRaw.rtc | wakeRaw.watchdog;
			end
			MODE_SHUTDOWN: begin
				wakeHit = wakeRaw.wakePinA | wakeRaw.wakePinB | wakeRaw.rtc;
			end
			default: begin
				wakeHit = 1'b0;
			end
		endcase
	end

	always_comb begin
		wakeLen = 16'(SLEEP_WAKE_CYC);
		unique case (mode_ff)
			MODE_STOP0: wakeLen = 16'(STOP0_WAKE_CYC);
			MODE_STOP1: wakeLen = 16'(STOP1_WAKE_CYC);
			MODE_STANDBY: wakeLen = 16'(STBY_WAKE_CYC);
			MODE_SHUTDOWN: wakeLen = 16'(SHDN_WAKE_CYC);
			default: wakeLen = 16'(SLEEP_WAKE_CYC);
		endcase
	end

	// mode sequencer
	always_comb begin
		nxt_state = state_ff;
		nxt_mode = mode_ff;
		nxt_wakeCnt = wakeCnt_ff;
		unique case (state_ff)
			ST_RUN: begin
				if (sleepReq) begin
					nxt_state = ST_LOWPWR;
					nxt_mode = modeSel;
				end
			end
			ST_LOWPWR: begin
				if (wakeHit) begin
					nxt_state = ST_WAKE;
					nxt_wakeCnt = wakeLen - 16'h0001;
				end
			end
			ST_WAKE: begin
				if (wakeCnt_ff == 16'h0000) begin
					nxt_state = ST_RUN;
				end else begin
					nxt_wakeCnt = wakeCnt_ff - 16'h0001;
				end
			end
			default: begin
				nxt_state = ST_RUN;
			end
		endcase
	end

	// wake interrupts latched in stop; a new event beats the clear
	always_comb begin
		nxt_serIrq = serIrq_ff;
		nxt_twIrq = twIrq_ff;
		if (state_ff == ST_RUN) begin
			nxt_serIrq = 1'b0;
			nxt_twIrq = 1'b0;
		end
		if (inStop && (|uartEvA || |uartEvB)) begin
			nxt_serIrq = 1'b1;
		end
		if (inStop && twoWireAddrMatch) begin
			nxt_twIrq = 1'b1;
		end
	end

	// fast internal oscillator only feeds requesters in stop
	always_comb begin
		nxt_grant = inStop ? fastOscReq : '0;
	end

	// pad pull capture; shutdown settings lost on exit
	always_comb begin
		nxt_padPull = padPull_ff;
		nxt_padCfg = padCfg_ff;
		if (padCfgDone) begin
			nxt_padPull = padPullCfg;
			nxt_padCfg = 1'b1;
		end
		if (state_ff == ST_WAKE && mode_ff == MODE_SHUTDOWN) begin
			nxt_padPull = '0;
			nxt_padCfg = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= ST_RUN;
			mode_ff <= MODE_SLEEP;
			wakeCnt_ff <= 16'h0000;
			padPull_ff <= '0;
			padCfg_ff <= 1'b0;
			grant_ff <= '0;
			serIrq_ff <= 1'b0;
			twIrq_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			mode_ff <= nxt_mode;
			wakeCnt_ff <= nxt_wakeCnt;
			padPull_ff <= nxt_padPull;
			padCfg_ff <= nxt_padCfg;
			grant_ff <= nxt_grant;
			serIrq_ff <= nxt_serIrq;
			twIrq_ff <= nxt_twIrq;
		end
	end

	// power domains per state
	always_comb begin
		pwrCtl = '0;
		pwrCtl.mainReg = 1'b1;
		pwrCtl.cpuClk = !inLow;
		pwrCtl.flashOn = 1'b1;
		pwrCtl.sramOn = 1'b1;
		pwrCtl.periphRun = 1'b1;
		pwrCtl.wakePeriphRun = 1'b1;
		pwrCtl.alwaysOnRun = 1'b1;
		pwrCtl.pllAllowed = 1'b1;
		pwrCtl.radioAvail = 1'b1;
		pwrCtl.rngAvail = 1'b1;
		pwrCtl.stepDownOn = 1'b1;
		if ((!inLow && lowPowerRunSel) || (inLow && mode_ff == MODE_LOW_POWER_SLEEP_MODE)) begin
			pwrCtl.mainReg = 1'b0;
			pwrCtl.lowPwrReg = 1'b1;
			pwrCtl.pllAllowed = 1'b0;
			pwrCtl.radioAvail = 1'b0;
			pwrCtl.rngAvail = 1'b0;
		end
		if (inLow && !isSleep(mode_ff)) begin
			pwrCtl.flashOn = 1'b0;
			pwrCtl.periphRun = 1'b0;
			pwrCtl.pllAllowed = 1'b0;
			pwrCtl.rngAvail = 1'b0;
			pwrCtl.mainReg = (mode_ff == MODE_STOP0);
			pwrCtl.lowPwrReg = (mode_ff == MODE_STOP1) || (mode_ff == MODE_STANDBY);
			pwrCtl.stepDownOn = (mode_ff == MODE_STOP0);
			if (mode_ff == MODE_STANDBY || mode_ff == MODE_SHUTDOWN) begin
				pwrCtl.wakePeriphRun = 1'b0;
				pwrCtl.radioAvail = 1'b0;
			end
			if (mode_ff == MODE_SHUTDOWN) begin
				pwrCtl.sramOn = 1'b0;
				pwrCtl.alwaysOnRun = 1'b0;
			end
		end
	end

	assign stateOut = state_ff;
	assign optActive = optEnable & ~OPT_EN_RST;
	assign fastOscGrant = grant_ff;
	assign fastOscOn = |grant_ff;
	assign fastXtalOn = !inLow || (inStop && radioActive);
	assign slowXtalOn = 1'b1;
	assign serialWakeIrq = serIrq_ff;
	assign twoWireWakeIrq = twIrq_ff;
	// gating only meaningful with the cpu asleep
	assign ramBankClkEn = (inLow && isSleep(mode_ff)) ? ~ramBankGate : 2'h3;
	assign flashPowerDown = flashPdReq && !radioActive && execFromRam;
	assign padPull = padPull_ff;
	assign padAnalog = !padCfg_ff;
	assign padTriggerEn = padCfg_ff;
	assign resetPullUpEn = !internalReset;
	assign wakeDone = (state_ff == ST_WAKE) && (wakeCnt_ff == 16'h0000);

	AST_STOP_OSC: assert property (@(posedge mclk) disable iff (!nrst)
		!inStop |=> fastOscGrant == '0) else $error("osc granted outside stop");
	AST_SER_IRQ: assert property (@(posedge mclk) disable iff (!nrst)
		inStop && uartEvA.startBit |=> serialWakeIrq) else $error("serial wake lost");
	AST_TW_IRQ: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(twoWireWakeIrq) |-> $past(twoWireAddrMatch)) else $error("bad i2c wake");
	AST_SHDN_PADS: assert property (@(posedge mclk) disable iff (!nrst)
		state_ff == ST_WAKE && mode_ff == MODE_SHUTDOWN && !padCfgDone |=> padPull == '0)
		else $error("shutdown pads kept");
	AST_SLEEP_WAKE: assert property (@(posedge mclk) disable iff (!nrst)
		inLow && mode_ff == MODE_SLEEP && wakeHit |-> ##[1:10] state_ff == ST_RUN)
		else $error("sleep wake too slow");
	AST_LP_NO_PLL: assert property (@(posedge mclk) disable iff (!nrst)
		inLow && mode_ff == MODE_LOW_POWER_SLEEP_MODE |-> !pwrCtl.pllAllowed && !pwrCtl.radioAvail)
		else $error("pll in low power");
	AST_STOP0: assert property (@(posedge mclk) disable iff (!nrst)
		inLow && mode_ff == MODE_STOP0 |-> pwrCtl.mainReg && !pwrCtl.flashOn)
		else $error("stop0 power wrong");
	AST_SHDN_WAKE: assert property (@(posedge mclk) disable iff (!nrst)
		inLow && mode_ff == MODE_SHUTDOWN && wakeRaw.brownout && !wakeRaw.rtc &&
		!wakeRaw.wakePinA && !wakeRaw.wakePinB |=> state_ff == ST_LOWPWR)
		else $error("shutdown woke wrongly");
	AST_XTAL: assert property (@(posedge mclk) disable iff (!nrst)
		inStop && radioActive |-> fastXtalOn) else $error("crystal off for radio");
	AST_FLASH_PD: assert property (@(posedge mclk) disable iff (!nrst)
		flashPowerDown |-> !radioActive && execFromRam) else $error("flash pd unsafe");
	AST_ENTER: assert property (@(posedge mclk) disable iff (!nrst)
		state_ff == ST_RUN && sleepReq |=> inLow && mode_ff == $past(modeSel))
		else $error("mode not entered");

	COV_STOP_WAKE: cover property (@(posedge mclk) disable iff (!nrst)
		inStop ##1 state_ff == ST_WAKE);
	COV_STBY_WAKE: cover property (@(posedge mclk) disable iff (!nrst)
		inLow && mode_ff == MODE_STANDBY && wakeRaw.wakePinA);
	COV_OSC: cover property (@(posedge mclk) disable iff (!nrst) fastOscOn);
endmodule
`default_nettype wire

/* tb/lpmm_periph_model.sv */
// peripheral side: fast oscillator requesters
`timescale 1ns/100ps
`default_nettype none
module lpmm_periph_model (
	input  wire logic       mclk,
	input  wire logic       nrst,
	input  wire logic [3:0] want,
	input  wire logic [3:0] grant,
	output logic [3:0]      oscReq,
	output logic            strayGrant
);
	logic [3:0] prevReq_ff;

	// a requester holds its line for as long as it needs the clock, granted or not
	// grant lags the request by one cycle, so it is held against the delayed request
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			oscReq <= 4'h0;
			prevReq_ff <= 4'h0;
			strayGrant <= 1'b0;
		end else begin
			oscReq <= want;
			prevReq_ff <= oscReq;
			strayGrant <= strayGrant | (|(grant & ~prevReq_ff));
		end
	end
endmodule
`default_nettype wire

/* tb/tb_lpmm_manager.sv */
// self-checking bench for the low power mode manager
`timescale 1ns/100ps
`default_nettype none
module tb_lpmm_manager;
	import lpmm_pkg::*;
	logic          mclk = 1'b0;
	logic          nrst = 1'b0;
	logic          sleepReq = 1'b0;
	lpmm_mode_t    modeSel = MODE_SLEEP;
	logic          lowPowerRunSel = 1'b0;
	logic [15:0]   optEnable = 16'h0000;
	logic [3:0]    oscWant = 4'h0;
	logic [3:0]    fastOscReq;
	logic          radioActive = 1'b0;
	lpmm_uart_ev_t uartEvA = '0;
	lpmm_uart_ev_t uartEvB = '0;
	logic          twoWireAddrMatch = 1'b0;
	lpmm_wake_t    wakeRaw = '0;
	logic [1:0]    ramBankGate = 2'h0;
	logic          flashPdReq = 1'b0;
	logic          execFromRam = 1'b0;
	logic [31:0]   padPullCfg = 32'h6A591248;
	logic          padCfgDone = 1'b0;
	logic          internalReset = 1'b0;
	lpmm_pwr_t     pwrCtl;
	lpmm_state_t   stateOut;
	logic [15:0]   optActive;
	logic [3:0]    fastOscGrant;
	logic          fastOscOn, fastXtalOn, slowXtalOn, serialWakeIrq, twoWireWakeIrq;
	logic [1:0]    ramBankClkEn;
	logic          flashPowerDown, padAnalog, padTriggerEn, resetPullUpEn, wakeDone;
	logic [31:0]   padPull;
	logic          strayGrant;
	int            fail_count = 0;
	int            n_compared = 0;

	always #4 mclk = ~mclk;

	lpmm_periph_model peri (.mclk(mclk), .nrst(nrst), .want(oscWant), .grant(fastOscGrant),
		.oscReq(fastOscReq), .strayGrant(strayGrant));
	lpmm_manager uut (.mclk(mclk), .nrst(nrst), .sleepReq(sleepReq), .modeSel(modeSel),
		.lowPowerRunSel(lowPowerRunSel), .optEnable(optEnable), .fastOscReq(fastOscReq),
		.radioActive(radioActive), .uartEvA(uartEvA), .uartEvB(uartEvB),
		.twoWireAddrMatch(twoWireAddrMatch), .wakeRaw(wakeRaw), .ramBankGate(ramBankGate),
		.flashPdReq(flashPdReq), .execFromRam(execFromRam), .padPullCfg(padPullCfg),
		.padCfgDone(padCfgDone), .internalReset(internalReset), .pwrCtl(pwrCtl),
		.stateOut(stateOut), .optActive(optActive), .fastOscGrant(fastOscGrant),
		.fastOscOn(fastOscOn), .fastXtalOn(fastXtalOn), .slowXtalOn(slowXtalOn),
		.serialWakeIrq(serialWakeIrq), .twoWireWakeIrq(twoWireWakeIrq),
		.ramBankClkEn(ramBankClkEn), .flashPowerDown(flashPowerDown), .padPull(padPull),
		.padAnalog(padAnalog), .padTriggerEn(padTriggerEn), .resetPullUpEn(resetPullUpEn),
		.wakeDone(wakeDone));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic enter(input lpmm_mode_t m);
		@(posedge mclk);
		sleepReq <= 1'b1;
		modeSel <= m;
		@(posedge mclk);
		sleepReq <= 1'b0;
		@(negedge mclk);
		chk(stateOut, ST_LOWPWR);
	endtask

	// counts wake cycles at falling edges; the wake must have been taken one edge before
	task automatic finish_wake(input int len);
		int n;
		int wd;
		n = 0;
		wd = 0;
		@(negedge mclk);
		while (stateOut === ST_WAKE && n < 7000) begin
			n++;
			if (wakeDone === 1'b1) wd++;
			@(negedge mclk);
		end
		if (n >= 7000) begin
			fail_count++;
			print_verdict();
		end else begin
			chk(n, len);
			chk(wd, 1);
			chk(stateOut, ST_RUN);
		end
	endtask

	// holds the source one edge, then counts the wake sequence
	task automatic wake(input logic [15:0] src, input int len);
		@(posedge mclk);
		wakeRaw <= lpmm_wake_t'(src);
		@(posedge mclk);
		wakeRaw <= '0;
		finish_wake(len);
	endtask

	task automatic refuse(input logic [15:0] src);
		@(posedge mclk);
		wakeRaw <= lpmm_wake_t'(src);
		repeat (3) @(posedge mclk);
		wakeRaw <= '0;
		@(negedge mclk);
		chk(stateOut, ST_LOWPWR);
	endtask

	initial begin
		lpmm_mode_t m;
		repeat (16) @(posedge mclk);
		chk({padAnalog, padTriggerEn, optActive}, 18'h20000);
		nrst <= 1'b1;
		@(negedge mclk);
		chk({stateOut, padAnalog, padTriggerEn}, {ST_RUN, 2'h2});
		internalReset <= 1'b1;
		optEnable <= 16'hA5C3;
		@(negedge mclk);
		chk({resetPullUpEn, optActive}, 17'h0A5C3);
		internalReset <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			{flashPdReq, radioActive, execFromRam} <= 3'(i);
			@(negedge mclk);
			chk(flashPowerDown, i == 5);
		end
		radioActive <= 1'b0;
		chk(resetPullUpEn, 1'b1);
		lowPowerRunSel <= 1'b1;
		@(negedge mclk);
		chk({pwrCtl.mainReg, pwrCtl.lowPwrReg, pwrCtl.pllAllowed, pwrCtl.radioAvail,
			pwrCtl.rngAvail, pwrCtl.cpuClk}, 6'h11);
		lowPowerRunSel <= 1'b0;
		enter(MODE_SLEEP);
		chk({pwrCtl.cpuClk, pwrCtl.flashOn, pwrCtl.sramOn, pwrCtl.mainReg}, 4'h7);
		wake(16'h0001, SLEEP_WAKE_CYC);
		enter(MODE_LOW_POWER_SLEEP_MODE);
		chk({pwrCtl.lowPwrReg, pwrCtl.pllAllowed, pwrCtl.radioAvail, pwrCtl.rngAvail}, 4'h8);
		ramBankGate <= 2'h1;
		@(negedge mclk);
		chk(ramBankClkEn, 2'h2);
		ramBankGate <= 2'h2;
		@(negedge mclk);
		chk(ramBankClkEn, 2'h1);
		wake(16'h0001, SLEEP_WAKE_CYC);
		chk(ramBankClkEn, 2'h3);
		// every stop source, alternating the two stop levels
		for (int i = 0; i < 13; i++) begin
			m = (i % 2) ? MODE_STOP1 : MODE_STOP0;
			enter(m);
			if (m == MODE_STOP0) begin
				chk({pwrCtl.mainReg, pwrCtl.flashOn, pwrCtl.sramOn, pwrCtl.stepDownOn}, 4'hB);
			end
			wake(16'h0008 << i, (m == MODE_STOP0) ? STOP0_WAKE_CYC : STOP1_WAKE_CYC);
		end
		// each event of both serial ports, then a two-wire address match; the latched irq wakes
		for (int i = 0; i < 7; i++) begin
			m = (i % 2) ? MODE_STOP1 : MODE_STOP0;
			enter(m);
			@(posedge mclk);
			if (i == 6) twoWireAddrMatch <= 1'b1;
			else if (i < 3) uartEvA <= lpmm_uart_ev_t'(3'h1 << i);
			else uartEvB <= lpmm_uart_ev_t'(3'h1 << (i - 3));
			@(posedge mclk);
			uartEvA <= '0;
			uartEvB <= '0;
			twoWireAddrMatch <= 1'b0;
			@(negedge mclk);
			chk({serialWakeIrq, twoWireWakeIrq}, (i == 6) ? 2'h1 : 2'h2);
			finish_wake((m == MODE_STOP0) ? STOP0_WAKE_CYC : STOP1_WAKE_CYC);
			// the irqs clear on the first edge spent in run
			@(negedge mclk);
			chk({serialWakeIrq, twoWireWakeIrq}, 2'h0);
		end
		// outside stop neither port may raise its wake irq
		@(posedge mclk);
		twoWireAddrMatch <= 1'b1;
		uartEvA <= lpmm_uart_ev_t'(3'h4);
		@(posedge mclk);
		twoWireAddrMatch <= 1'b0;
		uartEvA <= '0;
		@(negedge mclk);
		chk({serialWakeIrq, twoWireWakeIrq}, 2'h0);
		chk({fastOscGrant, fastXtalOn}, 5'h01);
		enter(MODE_STOP0);
		oscWant <= 4'h5;
		radioActive <= 1'b1;
		repeat (3) @(negedge mclk);
		chk({fastOscGrant, fastOscOn, fastXtalOn, stateOut}, 9'h0B9);
		oscWant <= 4'h0;
		radioActive <= 1'b0;
		repeat (3) @(negedge mclk);
		chk({fastOscOn, fastXtalOn}, 2'h0);
		wake(16'h0400, STOP0_WAKE_CYC);
		padCfgDone <= 1'b1;
		@(posedge mclk);
		padCfgDone <= 1'b0;
		@(negedge mclk);
		chk({padAnalog, padTriggerEn}, 2'h1);
		enter(MODE_STANDBY);
		chk(padPull, 32'h6A591248);
		chk({pwrCtl.periphRun, pwrCtl.alwaysOnRun}, 2'h1);
		refuse(16'h4000);
		wake(16'h0004, STBY_WAKE_CYC);
		enter(MODE_SHUTDOWN);
		chk({pwrCtl.mainReg, pwrCtl.lowPwrReg, pwrCtl.sramOn, slowXtalOn}, 4'h1);
		refuse(16'h1000);
		wake(16'h0002, SHDN_WAKE_CYC);
		chk({padAnalog, padTriggerEn}, 2'h2);
		chk(padPull, 32'h0);
		chk(strayGrant, 1'b0);
		print_verdict();
	end
endmodule
`default_nettype wire
